// [rtl/ch1_cfg_bank.sv]
/*
 Channel-one configuration bank: five byte registers reached through the
 internal register port of the serial control interface, decoded settings
 for the analog front end and digital path, and the phase-delay line for
 the channel's modulator bit stream.
 Assumes the control interface hands over single byte reads and writes
 synchronous to ref_clk, and that mod_tick marks one modulator clock.
*/
module ch1_cfg_bank
	import ch1_cfg_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_hit,
	// Mode bit from the enhancer mode register
	input wire logic enhancer_mode_bit,
	// Modulator stream
	input wire logic mod_tick,
	input wire logic mod_bit_in,
	output logic mod_bit_out,
	// Input setup
	output logic line_input,
	output logic [1:0] ch1_source_select,
	output logic pdm_selected,
	output logic dc_coupled,
	output logic [1:0] ch1_impedance_select,
	output logic range_enhancer_on,
	output logic automatic_gain_on,
	// Gain, volume, trim, phase delay and fault flag
	output logic [6:0] gain_half_db,
	output logic gain_negative,
	output logic volume_mute,
	output logic signed [8:0] volume_half_db,
	output logic signed [4:0] trim_tenth_db,
	output logic [7:0] ch1_phase_delay,
	output logic config_fault
);

	logic [7:0] setup_reg;
	logic [7:0] gain_reg;
	logic [7:0] volume_reg;
	logic [7:0] trim_reg;
	logic [7:0] phase_reg;
	logic [PHASE_TAPS-1:0] hist_reg;
	logic [7:0] rdata_next;
	logic hit_next;
	logic fault_next;

	// Register writes; masked bits of mixed registers stay zero
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			setup_reg <= RST_INPUT_SETUP;
			gain_reg <= RST_ANALOG_GAIN;
			volume_reg <= RST_VOLUME;
			trim_reg <= RST_GAIN_TRIM;
			phase_reg <= RST_PHASE_DELAY;
		end
		else if (reg_wr)
		begin
			if (reg_addr == OFS_INPUT_SETUP)
				setup_reg <= reg_wdata & MASK_INPUT_SETUP;
			else if (reg_addr == OFS_ANALOG_GAIN)
				gain_reg <= reg_wdata;
			else if (reg_addr == OFS_VOLUME)
				volume_reg <= reg_wdata;
			else if (reg_addr == OFS_GAIN_TRIM)
				trim_reg <= reg_wdata & MASK_GAIN_TRIM;
			else if (reg_addr == OFS_PHASE_DELAY)
				phase_reg <= reg_wdata;
		end
	end

	// Read decode; unmapped offsets read zero and leave reg_hit low
	always_comb
	begin
		rdata_next = 8'h00;
		hit_next = 1'b1;
		if (reg_addr == OFS_INPUT_SETUP)
			rdata_next = setup_reg;
		else if (reg_addr == OFS_ANALOG_GAIN)
			rdata_next = gain_reg;
		else if (reg_addr == OFS_VOLUME)
			rdata_next = volume_reg;
		else if (reg_addr == OFS_GAIN_TRIM)
			rdata_next = trim_reg;
		else if (reg_addr == OFS_PHASE_DELAY)
			rdata_next = phase_reg;
		else
			hit_next = 1'b0;
	end

	// Read data is held until the next read
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			reg_rdata <= 8'h00;
			reg_hit <= 1'b0;
		end
		else if (reg_rd)
		begin
			reg_rdata <= rdata_next;
			reg_hit <= hit_next;
		end
	end

	// Reserved codes and negative gain at 2.5k are software faults;
	// the bank keeps them but flags them rather than guessing a fix
	always_comb
	begin
		fault_next = 1'b0;
		if (setup_reg[POS_SRC_HI:POS_SRC_LO] == SRC_RSVD)
			fault_next = 1'b1;
		if (setup_reg[POS_IMP_HI:POS_IMP_LO] == IMP_RSVD)
			fault_next = 1'b1;
		if (gain_reg[7:1] > GAIN_CODE_MAX)
			fault_next = 1'b1;
		// negative gain only at 10k or 20k
		if (gain_reg[0] && setup_reg[POS_IMP_HI:POS_IMP_LO] == IMP_2K5)
			fault_next = 1'b1;
	end

	// Input setup decode, one cycle behind the register
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			line_input <= 1'b0;
			ch1_source_select <= SRC_DIFF;
			pdm_selected <= 1'b0;
			dc_coupled <= 1'b0;
			ch1_impedance_select <= IMP_2K5;
			range_enhancer_on <= 1'b0;
			automatic_gain_on <= 1'b0;
			config_fault <= 1'b0;
		end
		else
		begin
			line_input <= setup_reg[POS_INPUT_KIND];
			// source choice, pulse-density on code 2
			ch1_source_select <= setup_reg[POS_SRC_HI:POS_SRC_LO];
			pdm_selected <= setup_reg[POS_SRC_HI:POS_SRC_LO] == SRC_PDM;
			dc_coupled <= setup_reg[POS_COUPLING] &&
				(setup_reg[POS_SRC_HI:POS_SRC_LO] == SRC_DIFF ||
				setup_reg[POS_SRC_HI:POS_SRC_LO] == SRC_SINGLE);
			ch1_impedance_select <= setup_reg[POS_IMP_HI:POS_IMP_LO];
			range_enhancer_on <= setup_reg[POS_ENHANCER] &&
				!enhancer_mode_bit;
			automatic_gain_on <= setup_reg[POS_ENHANCER] &&
				enhancer_mode_bit;
			config_fault <= fault_next;
		end
	end

	// Gain, volume and trim in uniform step units, plus the phase delay code
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			gain_half_db <= 7'h00;
			gain_negative <= 1'b0;
			volume_mute <= 1'b0;
			volume_half_db <= 9'sh000;
			trim_tenth_db <= 5'sh00;
			ch1_phase_delay <= 8'h00;
		end
		else
		begin
			gain_half_db <= gain_reg[7:1];
			gain_negative <= gain_reg[0];
			volume_mute <= volume_reg == VOL_CODE_MUTE;
			// half-dB steps relative to unity code
			volume_half_db <= $signed({1'b0, volume_reg}) -
				$signed(VOL_CODE_UNITY);
			// trim relative to code 8, 0.1 dB steps
			trim_tenth_db <= $signed({1'b0, trim_reg[7:4]}) -
				$signed(TRIM_CODE_UNITY);
			ch1_phase_delay <= phase_reg;
		end
	end

	// Modulator history; a tap per past cycle keeps any delay one mux away
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			hist_reg <= '0;
		else if (mod_tick)
			hist_reg <= {hist_reg[PHASE_TAPS-2:0], mod_bit_in};
	end

	// output delayed by phase code in ticks
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			mod_bit_out <= 1'b0;
		else if (mod_tick)
		begin
			if (phase_reg == 8'h00)
				mod_bit_out <= mod_bit_in;
			else
				mod_bit_out <= hist_reg[phase_reg - 8'h01];
		end
	end

	// Checks on the registers and decoded outputs; those tied to a register look one edge
	// apart from it, since every decoded output is a flop behind it

	a_mute_decode: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		volume_mute |-> $past(volume_reg) == VOL_CODE_MUTE)
		else $error("mute without zero volume code");
	a_vol_unity: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		$past(volume_reg) == 8'hc9 |-> volume_half_db == 9'sh000)
		else $error("unity volume code not 0 dB");
	a_vol_top: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		$past(volume_reg) == 8'hff |-> volume_half_db == 9'sd54)
		else $error("top volume code not +27 dB");
	a_trim_unity: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		$past(trim_reg) == 8'h80 |-> trim_tenth_db == 5'sh00)
		else $error("trim code 8 not 0 dB");
	a_reserved_zero: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		setup_reg[1] == 1'b0 && trim_reg[3:0] == 4'h0)
		else $error("reserved bit set");
	a_dc_analog: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		dc_coupled |-> $past(setup_reg[6]) == 1'b0)
		else $error("dc coupling with digital source");
	a_enh_off: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		!setup_reg[0] |=> !range_enhancer_on && !automatic_gain_on)
		else $error("enhancer family on while disabled");
	a_kind_follow: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		reg_wr && reg_addr == OFS_INPUT_SETUP |-> ##2
		line_input == $past(reg_wdata[7], 2))
		else $error("input kind not taken from write");
	a_pdm_select: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		pdm_selected |-> ch1_source_select == SRC_PDM)
		else $error("pdm flag without code 2");
	a_imp_follow: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		ch1_impedance_select == $past(setup_reg[3:2]))
		else $error("impedance code not taken from register");
	a_gain_fault: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		gain_reg[7:1] > GAIN_CODE_MAX |=> config_fault)
		else $error("reserved gain code not flagged");
	a_neg_fault: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		gain_reg[0] && setup_reg[3:2] == IMP_2K5 |=> config_fault)
		else $error("negative gain at 2.5k not flagged");
	a_zero_delay: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		mod_tick && phase_reg == 8'h00 |=>
		mod_bit_out == $past(mod_bit_in))
		else $error("zero delay not direct");
	a_one_delay: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		mod_tick && phase_reg == 8'h01 |=>
		mod_bit_out == $past(hist_reg[0]))
		else $error("one-cycle delay wrong");

	c_pdm_source: cover property (@(posedge ref_clk) disable iff (!rstn)
		pdm_selected);
	c_muted: cover property (@(posedge ref_clk) disable iff (!rstn)
		volume_mute);
	c_auto_gain_on: cover property (@(posedge ref_clk) disable iff (!rstn)
		automatic_gain_on);
	c_range_on: cover property (@(posedge ref_clk) disable iff (!rstn)
		range_enhancer_on);
	c_long_delay: cover property (@(posedge ref_clk) disable iff (!rstn)
		mod_tick && phase_reg == 8'hff);

endmodule

// [rtl/ch1_cfg_pkg.sv]
/*
 Constants for the channel-one configuration bank: register offsets,
 field positions, reset values and code end points.
 Assumes byte-wide register access from the control interface.
*/
package ch1_cfg_pkg;

	// Register offsets
	localparam logic [7:0] OFS_INPUT_SETUP = 8'h3c;
	localparam logic [7:0] OFS_ANALOG_GAIN = 8'h3d;
	localparam logic [7:0] OFS_VOLUME = 8'h3e;
	localparam logic [7:0] OFS_GAIN_TRIM = 8'h3f;
	localparam logic [7:0] OFS_PHASE_DELAY = 8'h40;

	// Reset values
	localparam logic [7:0] RST_INPUT_SETUP = 8'h00;
	localparam logic [7:0] RST_ANALOG_GAIN = 8'h00;
	localparam logic [7:0] RST_VOLUME = 8'hc9;
	localparam logic [7:0] RST_GAIN_TRIM = 8'h80;
	localparam logic [7:0] RST_PHASE_DELAY = 8'h00;

	// Writable bits of the two mixed registers
	localparam logic [7:0] MASK_INPUT_SETUP = 8'hfd;
	localparam logic [7:0] MASK_GAIN_TRIM = 8'hf0;

	// Field positions in the input setup register
	localparam int POS_INPUT_KIND = 7;
	localparam int POS_SRC_HI = 6;
	localparam int POS_SRC_LO = 5;
	localparam int POS_COUPLING = 4;
	localparam int POS_IMP_HI = 3;
	localparam int POS_IMP_LO = 2;
	localparam int POS_ENHANCER = 0;

	// Source and impedance codes
	localparam logic [1:0] SRC_DIFF = 2'h0;
	localparam logic [1:0] SRC_SINGLE = 2'h1;
	localparam logic [1:0] SRC_PDM = 2'h2;
	localparam logic [1:0] SRC_RSVD = 2'h3;
	localparam logic [1:0] IMP_2K5 = 2'h0;
	localparam logic [1:0] IMP_RSVD = 2'h3;

	// Code end points
	localparam logic [6:0] GAIN_CODE_MAX = 7'h54;
	localparam logic [7:0] VOL_CODE_MUTE = 8'h00;
	localparam logic [8:0] VOL_CODE_UNITY = 9'h0c9;
	localparam logic [4:0] TRIM_CODE_UNITY = 5'h08;

	// Longest phase delay in modulator cycles
	localparam int PHASE_TAPS = 255;

endpackage

// [bench/test_channel_one_config_bank.sv]
/*
 Self-checking bench for the channel-one configuration bank.
 Assumes the bank takes register strobes at a rising edge and that its
 decoded outputs follow one edge after the write lands.
*/
module test_channel_one_config_bank import ch1_cfg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

`define CHK(what, exp, got) \
	begin \
		checked++; \
		if ((got) !== (exp)) \
		begin \
			bad_count++; \
			$display("unexpected %s: expected %0h, seen %0h", \
				what, exp, got); \
		end \
	end

	typedef struct {logic [7:0] a, d, r; logic h;} reg_row_s;
	typedef struct {logic [7:0] d; logic m; logic [9:0] x;} setup_row_s;
	logic ref_clk, rstn, reg_wr, reg_rd, enhancer_mode_bit;
	logic mod_tick, mod_bit_in, mod_bit_out, reg_hit, line_input;
	logic pdm_selected, dc_coupled, range_enhancer_on, automatic_gain_on;
	logic gain_negative, volume_mute, config_fault;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, phase;
	logic [1:0] src, imp;
	logic [6:0] gain;
	logic signed [8:0] vol;
	logic signed [4:0] trim;
	int bad_count, checked;
	// Readback rows: reserved bits drop, unmapped reads give zero
	reg_row_s regs[6] = '{'{8'h3c, 8'hff, 8'hfd, 1'b1},
		'{8'h3d, 8'ha8, 8'ha8, 1'b1}, '{8'h3e, 8'h00, 8'h00, 1'b1},
		'{8'h3f, 8'hff, 8'hf0, 1'b1}, '{8'h40, 8'hff, 8'hff, 1'b1},
		'{8'h41, 8'h77, 8'h00, 1'b0}};
	// Setup rows: kind, source, pdm, dc, impedance, enhancer, auto gain,
	// fault
	setup_row_s setups[8] = '{'{8'h00, 1'b0, 10'b0_00_0_0_00_0_0_0},
		'{8'h91, 1'b0, 10'b1_00_0_1_00_1_0_0},
		'{8'h49, 1'b1, 10'b0_10_1_0_10_0_1_0},
		'{8'h50, 1'b0, 10'b0_10_1_0_00_0_0_0},
		'{8'h35, 1'b1, 10'b0_01_0_1_01_0_1_0},
		'{8'h88, 1'b1, 10'b1_00_0_0_10_0_0_0},
		'{8'h60, 1'b0, 10'b0_11_0_0_00_0_0_1},
		'{8'h0c, 1'b0, 10'b0_00_0_0_11_0_0_1}};

	ch1_cfg_bank dut_u (.ref_clk(ref_clk), .rstn(rstn),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
		.enhancer_mode_bit(enhancer_mode_bit), .mod_tick(mod_tick),
		.mod_bit_in(mod_bit_in), .mod_bit_out(mod_bit_out),
		.line_input(line_input), .ch1_source_select(src),
		.pdm_selected(pdm_selected), .dc_coupled(dc_coupled),
		.ch1_impedance_select(imp), .range_enhancer_on(range_enhancer_on),
		.automatic_gain_on(automatic_gain_on), .gain_half_db(gain),
		.gain_negative(gain_negative), .volume_mute(volume_mute),
		.volume_half_db(vol), .trim_tenth_db(trim),
		.ch1_phase_delay(phase), .config_fault(config_fault));

	// Free-running 25 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// Single write; strobe drops at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
	endtask

	// Decoded outputs trail the register by one edge
	task automatic settle();
		@(posedge ref_clk);
		#1;
	endtask

	// Stream n ticks back to back and compare each delayed bit
	task automatic run_phase(input int d);
		logic [15:0] pat;
		int n;
		pat = 16'hb2e5;
		n = d + 17;
		wr(OFS_PHASE_DELAY, 8'(d));
		for (int i = 0; i < n; i++)
		begin
			@(posedge ref_clk);
			mod_tick <= 1'b1;
			mod_bit_in <= pat[i % 16];
			@(negedge ref_clk);
			if (i > d)
				`CHK("delayed bit", pat[(i - 1 - d) % 16], mod_bit_out)
		end
		@(posedge ref_clk);
		mod_tick <= 1'b0;
		repeat (3) @(negedge ref_clk);
		`CHK("held bit", pat[(n - 1 - d) % 16], mod_bit_out)
		$display("phase delay %0d done", d);
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Watchdog so a stuck run still reaches the verdict
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		$display("run timed out");
		tally_and_finish();
	end

	initial
	begin
		{rstn, reg_wr, reg_rd, enhancer_mode_bit, mod_tick, mod_bit_in} = '0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		foreach (regs[i])
		begin
			wr(regs[i].a, regs[i].d);
			rd(regs[i].a);
			`CHK("readback", regs[i].r, reg_rdata)
			`CHK("hit", regs[i].h, reg_hit)
		end
		$display("register readback done");
		wr(OFS_ANALOG_GAIN, 8'h00);
		foreach (setups[i])
		begin
			@(posedge ref_clk);
			enhancer_mode_bit <= setups[i].m;
			wr(OFS_INPUT_SETUP, setups[i].d);
			settle();
			`CHK("kind", setups[i].x[9], line_input)
			`CHK("source", setups[i].x[8:7], src)
			`CHK("pdm flag", setups[i].x[6], pdm_selected)
			`CHK("coupling", setups[i].x[5], dc_coupled)
			`CHK("impedance", setups[i].x[4:3], imp)
			`CHK("range", setups[i].x[2], range_enhancer_on)
			`CHK("auto gain", setups[i].x[1], automatic_gain_on)
			`CHK("fault", setups[i].x[0], config_fault)
		end
		$display("input setup done");
		// Gain end point, reserved code, and negative gain at 2.5k
		wr(OFS_INPUT_SETUP, 8'h00);
		wr(OFS_ANALOG_GAIN, 8'ha8);
		settle();
		`CHK("gain", 8'ha8, {gain, config_fault})
		wr(OFS_ANALOG_GAIN, 8'haa);
		settle();
		`CHK("gain rsvd", 8'hab, {gain, config_fault})
		wr(OFS_ANALOG_GAIN, 8'h01);
		settle();
		`CHK("neg 2k5", 2'b11, {gain_negative, config_fault})
		wr(OFS_INPUT_SETUP, 8'h04);
		settle();
		`CHK("neg 10k", 2'b10, {gain_negative, config_fault})
		$display("gain done");
		foreach (regs[i])
		begin
			wr(OFS_VOLUME, 8'(i * 51));
			settle();
			`CHK("mute", i == 0, volume_mute)
			`CHK("volume", 9'(i * 51 - 201), vol)
			wr(OFS_GAIN_TRIM, 8'(i * 51));
			settle();
			`CHK("trim", 5'((i * 51) / 16 - 8), trim)
		end
		$display("volume and trim done");
		// Read in the same cycle as a write returns the old value
		@(posedge ref_clk);
		reg_addr <= OFS_PHASE_DELAY;
		reg_wdata <= 8'h5a;
		{reg_wr, reg_rd} <= 2'b11;
		@(posedge ref_clk);
		{reg_wr, reg_rd} <= 2'b00;
		#1;
		`CHK("old read", 8'hff, reg_rdata)
		rd(OFS_PHASE_DELAY);
		`CHK("new read", 8'h5a, reg_rdata)
		`CHK("phase out", 8'h5a, phase)
		$display("same-cycle access done");
		run_phase(0);
		run_phase(1);
		run_phase(255);
		// Mid-run reset restores every register
		@(posedge ref_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		rd(OFS_INPUT_SETUP);
		`CHK("rst setup", RST_INPUT_SETUP, reg_rdata)
		rd(OFS_ANALOG_GAIN);
		`CHK("rst gain", RST_ANALOG_GAIN, reg_rdata)
		rd(OFS_VOLUME);
		`CHK("rst volume", RST_VOLUME, reg_rdata)
		rd(OFS_GAIN_TRIM);
		`CHK("rst trim", RST_GAIN_TRIM, reg_rdata)
		rd(OFS_PHASE_DELAY);
		`CHK("rst phase", RST_PHASE_DELAY, reg_rdata)
		$display("reset values done");
		tally_and_finish();
	end
endmodule
